// ===== src/temp_msg_pkg.sv
// Purpose: shared constants and types for the temporary message parser
// Assumes: 8-bit serial characters delivered one per rxValid pulse
// Notes: all cycle counts derive from the system clock rate
package temp_msg_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int PROC_LIMIT_MS = 10;
    localparam int PROC_LIMIT_CYC = PROC_LIMIT_MS * (CLK_HZ / 1000);
    // ****************************************
    // characters
    // ****************************************
    localparam logic [7:0] PFX_A = 8'h1F;
    localparam logic [7:0] PFX_B = 8'h5E;
    localparam logic [7:0] CTL_LO = 8'h20;
    localparam logic [7:0] CTL_HI = 8'h2C;
    localparam logic [7:0] EXT_OFS = 8'h50;
    localparam logic [7:0] EXT_LO = 8'h80;
    localparam logic [7:0] EXT_HI = 8'hB8;
    localparam logic [7:0] C_BLINK = 8'h20;
    localparam logic [7:0] C_PIN = 8'h23;
    localparam logic [7:0] C_TMO = 8'h24;
    localparam logic [7:0] C_BLOCK = 8'h26;
    localparam logic [7:0] C_CHSCR = 8'h27;
    localparam logic [7:0] C_TERM = 8'h28;
    localparam logic [7:0] C_EOB = 8'h29;
    localparam logic [7:0] C_EOL = 8'h2B;
    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] DIG_0 = 8'h30;
    localparam logic [7:0] TERM_RST = 8'h0D;
    // ****************************************
    // timeout and pin encodings
    // ****************************************
    localparam logic [7:0] TMO_NEVER = 8'hFF;
    localparam int TMO_MS_BIT = 7;
    localparam int TMO_MIN_BIT = 6;
    localparam int PIN_UNLOCK = 7;
    localparam int PIN_ON = 6;
    localparam int PIN_OFF = 5;
    localparam int PIN_TOGGLE = 4;
    localparam int PIN_LOCK = 3;
    localparam int PIN_HALT = 2;
    localparam int PIN_RUNDEF = 1;
    localparam int PIN_RUN = 0;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {SCR_NONE = 2'h0, SCR_BLOCK = 2'h1, SCR_CHAR = 2'h2} scroll_t;
    typedef enum logic [1:0] {TU_NONE = 2'h0, TU_10MS = 2'h1, TU_SEC = 2'h2,
        TU_MIN = 2'h3} tmo_unit_t;
endpackage

// ===== src/msg_buf_if.sv
// Purpose: write and read port bundle for the message text buffer
// Assumes: single clock
// Notes: read data is registered inside the memory
`timescale 1ns/100ps
interface msg_buf_if #(parameter int AW = 7);
    logic wrEn;
    logic [AW-1:0] wrAddr;
    logic [9:0] wrData;
    logic [AW-1:0] rdAddr;
    logic [9:0] rdData;
    modport owner (output wrEn, wrAddr, wrData, rdAddr, input rdData);
    modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface

// ===== src/msg_buf_mem.sv
// Purpose: message text store, one entry per decoded display character
// Assumes: entry holds char, bottom-line flag and blink flag
// Notes: read data comes out of a register one cycle after the address
`timescale 1ns/100ps
module msg_buf_mem #(
    parameter int AW = 7
) (
    // clock
    input wire logic clk_sys,
    // port bundle
    msg_buf_if.mem bus
);
    logic [9:0] store [0:(1<<AW)-1];
    logic [9:0] rdData_ff;

    // write and registered read
    always_ff @(posedge clk_sys) begin
        if (bus.wrEn) begin
            store[bus.wrAddr] <= bus.wrData;
        end
        rdData_ff <= store[bus.rdAddr];
    end

    assign bus.rdData = rdData_ff;
endmodule

// ===== src/temp_message_parser.sv
// Purpose: parse serial temporary message strings and run their steps
// Assumes: rxData/rxValid come from a UART on clk_sys; termChar is static
// Notes: host must not send while busy; display reads buffer after showStart
`timescale 1ns/100ps
// Function
// - serial text is a temporary message, no priority, never queued
// - next display-bound request replaces the shown temporary message
// - processing starts only when the terminator arrives
// - one string processed at a time, next waits until done
// - processing ends within 10 ms, no serial input meanwhile
// - order: output pin, timers, line scrolling, show and start timeout
// - control sequence is two chars; both prefix chars interchangeable
// - second character 20h to 2Ch is a control character
// - other prefixed character plus 50h rebuilds extended char 80h-B8h
// - line-break sequence moves following text to bottom line
// - block-scroll sequence scrolls the line; end-of-block splits blocks
// - end of each line is an implicit end of block
// - char-scroll sequence scrolls line; end-of-block splits scrolled blocks
// - text between two blink sequences blinks at its line's rate
// - literal-terminator sequence becomes terminator text, not end
// - respond to temporary strings exactly as a slave display does
// - timeout digits: 128+n tens of ms, 64+n minutes, n seconds, 255 never
// - pin digits: unlock, on, off, toggle, lock, halt, run default, run
module temp_message_parser #(
    parameter int AW = 7,
    parameter int PROC_CYC = temp_msg_pkg::PROC_LIMIT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial characters
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic [7:0] termChar,
    // display side
    input wire logic [AW-1:0] dispAddr,
    output logic [9:0] dispData,
    output logic showStart,
    output logic [AW-1:0] msgLen,
    output logic [1:0] scrollTop,
    output logic [1:0] scrollBot,
    output logic [(1<<AW)-1:0] eobMask,
    // timeout and pin
    output logic [1:0] tmoUnit,
    output logic [5:0] tmoValue,
    output logic [6:0] tmoMs,
    output logic pinCfgStb,
    output logic [7:0] pinFlags,
    output logic timerCfgStb,
    // status
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_PIN = 3'h1, ST_TIMER = 3'h3, ST_SCROLL = 3'h2, ST_SHOW = 3'h6
    } step_t;
    typedef enum logic [2:0] {
        PS_HDR = 3'h0, PS_TEXT = 3'h1, PS_CTL = 3'h3, PS_DIG = 3'h2, PS_SKIP = 3'h6
    } parse_t;

    msg_buf_if #(.AW(AW)) buf_bus ();

    step_t step_ff;
    parse_t parse_ff;
    logic [AW-1:0] wptr_ff;
    logic bottom_ff;
    logic blink_ff;
    logic [1:0] scrT_ff, scrB_ff;
    logic [(1<<AW)-1:0] eob_ff;
    logic [1:0] digCnt_ff;
    logic [7:0] digAcc_ff;
    logic digPin_ff;
    logic pinReq_ff;
    logic [7:0] pinVal_ff;
    logic [7:0] tmoVal_ff;
    logic [23:0] procCnt_ff;
    logic [1:0] hdrCnt_ff;
    logic showStart_ff, pinStb_ff, timStb_ff, busy_ff;
    logic [AW-1:0] msgLen_ff;
    logic [1:0] scrollTop_ff, scrollBot_ff, tmoUnit_ff;
    logic [(1<<AW)-1:0] eobMask_ff;
    logic [5:0] tmoValue_ff;
    logic [6:0] tmoMs_ff;
    logic [7:0] pinFlags_ff;
    logic [7:0] nxt_dig;
    logic rxTake, isPfx, isTerm;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic prefix_char(input logic [7:0] c);
        prefix_char = (c == temp_msg_pkg::PFX_A) || (c == temp_msg_pkg::PFX_B);
    endfunction

    function automatic logic [7:0] ext_char(input logic [7:0] c);
        ext_char = c + temp_msg_pkg::EXT_OFS;
    endfunction

    // ****************************************
    // text buffer
    // ****************************************
    msg_buf_mem #(.AW(AW)) u_mem (
        .clk_sys(clk_sys),
        .bus(buf_bus.mem)
    );

    // input is refused while a string is being processed
    assign rxTake = rxValid && (step_ff == ST_IDLE);
    assign isPfx = prefix_char(rxData);
    assign isTerm = (rxData == termChar);
    assign nxt_dig = 8'((digAcc_ff * 8'h0A) + (rxData - temp_msg_pkg::DIG_0));
    assign buf_bus.rdAddr = dispAddr;

    // buffer write: text chars, with line and blink attributes
    always_comb begin
        buf_bus.wrEn = 1'b0;
        buf_bus.wrAddr = wptr_ff;
        buf_bus.wrData = {bottom_ff, blink_ff, rxData};
        if (rxTake && parse_ff == PS_TEXT && !isPfx && !isTerm) begin
            buf_bus.wrEn = 1'b1;
        end else if (rxTake && parse_ff == PS_CTL) begin
            if (rxData == temp_msg_pkg::C_TERM) begin
                buf_bus.wrEn = 1'b1;
                buf_bus.wrData = {bottom_ff, blink_ff, termChar};
            end else if (rxData < temp_msg_pkg::CTL_LO || rxData > temp_msg_pkg::CTL_HI) begin
                buf_bus.wrEn = 1'b1;
                buf_bus.wrData = {bottom_ff, blink_ff, ext_char(rxData)};
            end
        end
    end

    // ****************************************
    // character parser
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            parse_ff <= PS_HDR;
            hdrCnt_ff <= 2'h0;
        end else if (step_ff == ST_SHOW) begin
            parse_ff <= PS_HDR;
            hdrCnt_ff <= 2'h0;
        end else if (rxTake) begin
            case (parse_ff)
                PS_HDR: begin
                    // accept M: header, also as tail of numbered command prefix
                    if (rxData == temp_msg_pkg::CH_COLON && hdrCnt_ff == 2'h1) begin
                        parse_ff <= PS_TEXT;
                    end else if (rxData == temp_msg_pkg::CH_M) begin
                        hdrCnt_ff <= 2'h1;
                    end else begin
                        hdrCnt_ff <= 2'h0;
                    end
                end
                PS_TEXT: begin
                    if (isTerm) begin
                        parse_ff <= PS_HDR;
                    end else if (isPfx) begin
                        parse_ff <= PS_CTL;
                    end
                end
                PS_CTL: begin
                    if (rxData == temp_msg_pkg::C_PIN || rxData == temp_msg_pkg::C_TMO) begin
                        parse_ff <= PS_DIG;
                    end else begin
                        parse_ff <= PS_TEXT;
                    end
                end
                PS_DIG: begin
                    if (digCnt_ff == 2'h2) begin
                        parse_ff <= PS_TEXT;
                    end
                end
                default: begin
                    parse_ff <= PS_HDR;
                end
            endcase
        end
    end

    // write pointer, line, blink, scroll and block marks
    always_ff @(posedge clk_sys) begin
        if (rst || step_ff == ST_SHOW) begin
            wptr_ff <= '0;
            bottom_ff <= 1'b0;
            blink_ff <= 1'b0;
            scrT_ff <= temp_msg_pkg::SCR_NONE;
            scrB_ff <= temp_msg_pkg::SCR_NONE;
            eob_ff <= '0;
        end else begin
            if (buf_bus.wrEn) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (rxTake && parse_ff == PS_CTL) begin
                case (rxData)
                    temp_msg_pkg::C_EOL: begin
                        bottom_ff <= 1'b1;
                        if (wptr_ff != '0) begin
                            eob_ff[wptr_ff - 1'b1] <= 1'b1;
                        end
                    end
                    temp_msg_pkg::C_BLINK: blink_ff <= ~blink_ff;
                    temp_msg_pkg::C_EOB: begin
                        if (wptr_ff != '0) begin
                            eob_ff[wptr_ff - 1'b1] <= 1'b1;
                        end
                    end
                    temp_msg_pkg::C_BLOCK: begin
                        if (bottom_ff) scrB_ff <= temp_msg_pkg::SCR_BLOCK;
                        else scrT_ff <= temp_msg_pkg::SCR_BLOCK;
                    end
                    temp_msg_pkg::C_CHSCR: begin
                        if (bottom_ff) scrB_ff <= temp_msg_pkg::SCR_CHAR;
                        else scrT_ff <= temp_msg_pkg::SCR_CHAR;
                    end
                    default: begin
                    end
                endcase
            end
            if (rxTake && parse_ff == PS_TEXT && isTerm && wptr_ff != '0) begin
                eob_ff[wptr_ff - 1'b1] <= 1'b1;
            end
        end
    end

    // three-digit fields for pin and timeout
    always_ff @(posedge clk_sys) begin
        if (rst || step_ff == ST_SHOW) begin
            digCnt_ff <= 2'h0;
            digAcc_ff <= 8'h00;
            digPin_ff <= 1'b0;
            pinReq_ff <= 1'b0;
            pinVal_ff <= 8'h00;
            tmoVal_ff <= temp_msg_pkg::TMO_NEVER;
        end else if (rxTake) begin
            if (parse_ff == PS_CTL) begin
                digPin_ff <= (rxData == temp_msg_pkg::C_PIN);
                digCnt_ff <= 2'h0;
                digAcc_ff <= 8'h00;
            end else if (parse_ff == PS_DIG) begin
                digAcc_ff <= nxt_dig;
                digCnt_ff <= digCnt_ff + 2'h1;
                if (digCnt_ff == 2'h2) begin
                    if (digPin_ff) begin
                        pinReq_ff <= 1'b1;
                        pinVal_ff <= nxt_dig;
                    end else begin
                        tmoVal_ff <= nxt_dig;
                    end
                end
            end
        end
    end

    // ****************************************
    // processing sequence
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_ff <= ST_IDLE;
        end else begin
            case (step_ff)
                ST_IDLE: if (rxTake && parse_ff == PS_TEXT && isTerm) step_ff <= ST_PIN;
                ST_PIN: step_ff <= ST_TIMER;
                ST_TIMER: step_ff <= ST_SCROLL;
                ST_SCROLL: step_ff <= ST_SHOW;
                ST_SHOW: step_ff <= ST_IDLE;
                default: step_ff <= ST_IDLE;
            endcase
        end
    end

    // busy flag and processing time watch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_ff <= 1'b0;
            procCnt_ff <= '0;
        end else begin
            busy_ff <= (step_ff != ST_IDLE && step_ff != ST_SHOW)
                || (rxTake && parse_ff == PS_TEXT && isTerm);
            procCnt_ff <= (step_ff == ST_IDLE) ? '0 : procCnt_ff + 24'h1;
        end
    end

    // step outputs, each in its fixed slot
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinStb_ff <= 1'b0;
            pinFlags_ff <= 8'h00;
            timStb_ff <= 1'b0;
            scrollTop_ff <= temp_msg_pkg::SCR_NONE;
            scrollBot_ff <= temp_msg_pkg::SCR_NONE;
            eobMask_ff <= '0;
            showStart_ff <= 1'b0;
            msgLen_ff <= '0;
            tmoUnit_ff <= temp_msg_pkg::TU_NONE;
            tmoValue_ff <= 6'h00;
            tmoMs_ff <= 7'h00;
        end else begin
            pinStb_ff <= (step_ff == ST_PIN) && pinReq_ff;
            timStb_ff <= (step_ff == ST_TIMER);
            showStart_ff <= (step_ff == ST_SHOW);
            if (step_ff == ST_PIN && pinReq_ff) pinFlags_ff <= pinVal_ff;
            if (step_ff == ST_SCROLL) begin
                scrollTop_ff <= scrT_ff;
                scrollBot_ff <= scrB_ff;
                eobMask_ff <= eob_ff;
            end
            if (step_ff == ST_SHOW) begin
                msgLen_ff <= wptr_ff;
                if (tmoVal_ff == temp_msg_pkg::TMO_NEVER) begin
                    tmoUnit_ff <= temp_msg_pkg::TU_NONE;
                end else if (tmoVal_ff[temp_msg_pkg::TMO_MS_BIT]) begin
                    tmoUnit_ff <= temp_msg_pkg::TU_10MS;
                end else if (tmoVal_ff[temp_msg_pkg::TMO_MIN_BIT]) begin
                    tmoUnit_ff <= temp_msg_pkg::TU_MIN;
                end else begin
                    tmoUnit_ff <= temp_msg_pkg::TU_SEC;
                end
                tmoValue_ff <= tmoVal_ff[5:0];
                tmoMs_ff <= tmoVal_ff[6:0];
            end
        end
    end

    assign dispData = buf_bus.rdData;
    assign showStart = showStart_ff;
    assign msgLen = msgLen_ff;
    assign scrollTop = scrollTop_ff;
    assign scrollBot = scrollBot_ff;
    assign eobMask = eobMask_ff;
    assign tmoUnit = tmoUnit_ff;
    assign tmoValue = tmoValue_ff;
    assign tmoMs = tmoMs_ff;
    assign pinCfgStb = pinStb_ff;
    assign pinFlags = pinFlags_ff;
    assign timerCfgStb = timStb_ff;
    assign busy = busy_ff;

    // ****************************************
    // checks
    // ****************************************
    sequence s_term;
        rxTake && parse_ff == PS_TEXT && isTerm;
    endsequence
    sequence s_steps;
        step_ff == ST_PIN ##1 step_ff == ST_TIMER ##1 step_ff == ST_SCROLL ##1 step_ff == ST_SHOW;
    endsequence

    a_step_order: assert property (@(posedge clk_sys) disable iff (rst)
        s_term |=> s_steps) else $error("processing steps out of order");
    a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
        s_term |=> busy [*4]) else $error("busy dropped during processing");
    a_show_end: assert property (@(posedge clk_sys) disable iff (rst)
        s_term |-> ##5 showStart) else $error("show not issued in time");
    a_proc_limit: assert property (@(posedge clk_sys) disable iff (rst)
        procCnt_ff < PROC_CYC) else $error("processing exceeded limit");
    a_no_rx_busy: assert property (@(posedge clk_sys) disable iff (rst)
        busy |-> !rxTake && !buf_bus.wrEn) else $error("input taken while processing");
    a_ext_rebuild: assert property (@(posedge clk_sys) disable iff (rst)
        rxTake && parse_ff == PS_CTL
        && (rxData < temp_msg_pkg::CTL_LO || rxData > temp_msg_pkg::CTL_HI)
        |-> buf_bus.wrEn && buf_bus.wrData[7:0] == rxData + temp_msg_pkg::EXT_OFS)
        else $error("extended char not rebuilt");
    a_lit_term: assert property (@(posedge clk_sys) disable iff (rst)
        rxTake && parse_ff == PS_CTL && rxData == temp_msg_pkg::C_TERM
        |=> step_ff == ST_IDLE && wptr_ff == $past(wptr_ff) + 1'b1)
        else $error("literal terminator mishandled");
    a_line_break: assert property (@(posedge clk_sys) disable iff (rst)
        rxTake && parse_ff == PS_CTL && rxData == temp_msg_pkg::C_EOL |=> bottom_ff)
        else $error("line break not applied");
    a_pin_slot: assert property (@(posedge clk_sys) disable iff (rst)
        pinCfgStb |-> timerCfgStb == 1'b0 ##1 timerCfgStb)
        else $error("pin strobe not before timers");
endmodule

// ===== tb/host_model.sv
// Purpose: host side model that sends temporary message strings
// Assumes: one character per clock, back to back, terminator appended last when withTerm is set
// Notes: a released data line shows the inverse of the last character
`timescale 1ns/100ps
module host_model (
    // clock and status
    input wire logic clk_sys,
    input wire logic busy,
    input wire logic [7:0] termChar,
    // serial characters
    output logic [7:0] rxData,
    output logic rxValid
);
    // ****************************************
    // character driver
    // ****************************************
    // idle line at time zero
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
    end
    // send text, optionally closed by the terminator
    task automatic send_str(input string s, input bit withTerm);
        int n;
        int i;
        n = 0;
        @(posedge clk_sys);
        #1;
        // hold off while the unit is processing
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // still busy: send nothing, the bench wait then times out
        if (busy !== 1'b0) begin
            return;
        end
        for (i = 0; i < s.len(); i++) begin
            rxData = s[i];
            rxValid = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        if (withTerm) begin
            rxData = termChar;
            rxValid = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        rxValid = 1'b0;
        rxData = ~rxData;
    endtask
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the temporary message parser
// Assumes: terminator fixed to 2Ah, shortened processing limit
// Notes: each scenario sends whole strings (s_basic also one split before its terminator) and judges the outputs
`timescale 1ns/100ps
module tb;
    localparam int AW = 7;
    localparam int PCYC = 50;
    localparam logic [7:0] TERM = 8'h2A;
    logic clk_sys = 1'b0;
    logic rst;
    logic [7:0] rxData;
    logic rxValid;
    logic [AW-1:0] dispAddr;
    logic [9:0] dispData;
    logic showStart;
    logic [AW-1:0] msgLen;
    logic [1:0] scrollTop;
    logic [1:0] scrollBot;
    logic [(1<<AW)-1:0] eobMask;
    logic [1:0] tmoUnit;
    logic [5:0] tmoValue;
    logic [6:0] tmoMs;
    logic pinCfgStb;
    logic [7:0] pinFlags;
    logic timerCfgStb;
    logic busy;
    int fails;
    int total_checks;
    int pinAt;
    int tmrAt;
    int showAt;
    // ****************************************
    // clock, design and host
    // ****************************************
    always #5 clk_sys = ~clk_sys;
    temp_message_parser #(.AW(AW), .PROC_CYC(PCYC)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .rxData(rxData), .rxValid(rxValid), .termChar(TERM), .dispAddr(dispAddr),
        .dispData(dispData), .showStart(showStart), .msgLen(msgLen), .scrollTop(scrollTop),
        .scrollBot(scrollBot), .eobMask(eobMask), .tmoUnit(tmoUnit), .tmoValue(tmoValue),
        .tmoMs(tmoMs), .pinCfgStb(pinCfgStb), .pinFlags(pinFlags),
        .timerCfgStb(timerCfgStb), .busy(busy));
    host_model i_host (.clk_sys(clk_sys), .busy(busy), .termChar(TERM), .rxData(rxData),
        .rxValid(rxValid));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
            fails++;
        end
    endtask
    // read one display entry, data registered one cycle after the address
    task automatic rdchk(input int a, input logic [9:0] exp);
        @(posedge clk_sys);
        #1;
        dispAddr = AW'(a);
        @(posedge clk_sys);
        #1;
        chk(dispData, exp, "display entry");
    endtask
    // bounded wait for showStart, recording step strobes
    task automatic wait_show();
        int n;
        int gap;
        gap = 0;
        pinAt = -1;
        tmrAt = -1;
        showAt = -1;
        for (n = 0; n < 200 && showAt < 0; n++) begin
            @(posedge clk_sys);
            #1;
            if (pinCfgStb === 1'b1) pinAt = n;
            if (timerCfgStb === 1'b1) tmrAt = n;
            if (showStart === 1'b1) showAt = n;
            else if (busy !== 1'b1) gap++;
        end
        if (showAt < 0) begin
            $display("MISMATCH t=%0t showStart never came", $time);
            fails++;
            summarize();
        end
        chk(showAt < PCYC, 1, "processing time");
        chk(gap, 0, "busy gap");
        @(posedge clk_sys);
        #1;
        chk(showStart, 0, "showStart width");
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_basic();
        int n;
        int seen;
        string hdr;
        seen = 0;
        i_host.send_str("M:AB", 1'b0);
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            #1;
            if (showStart !== 1'b0 || busy !== 1'b0) seen++;
        end
        chk(seen, 0, "start before terminator");
        i_host.send_str("", 1'b1);
        wait_show();
        chk(msgLen, 2, "length");
        rdchk(0, 10'h041);
        chk(tmoUnit, temp_msg_pkg::TU_NONE, "default timeout");
        hdr = "C21";
        hdr = {hdr, "M:Q"};
        i_host.send_str(hdr, 1'b1);
        wait_show();
        chk(msgLen, 1, "replaced length");
        rdchk(0, 10'h051);
        chk(scrollTop, temp_msg_pkg::SCR_NONE, "no scroll");
    endtask
    task automatic s_ext();
        logic [9:0] exp [5] = '{10'h081, 10'h081, 10'h078, 10'h0B8, 10'h07D};
        int i;
        i_host.send_str("M:\0371^1x^h^,^-", 1'b1);
        wait_show();
        chk(msgLen, 5, "extended length");
        for (i = 0; i < 5; i++) begin
            rdchk(i, exp[i]);
        end
    endtask
    task automatic s_lines();
        i_host.send_str("M:^&AB^)C^+^'DE", 1'b1);
        wait_show();
        chk(scrollTop, temp_msg_pkg::SCR_BLOCK, "top block scroll");
        chk(scrollBot, temp_msg_pkg::SCR_CHAR, "bottom char scroll");
        chk(eobMask[31:0], 32'h0000_0016, "block ends");
        rdchk(2, 10'h043);
        rdchk(3, 10'h244);
    endtask
    task automatic s_blink();
        i_host.send_str("M:^ X^ Y^(", 1'b1);
        wait_show();
        chk(msgLen, 3, "blink length");
        rdchk(0, 10'h158);
        rdchk(1, 10'h059);
        rdchk(2, {2'b00, TERM});
    endtask
    task automatic s_pin();
        string m [4] = '{"M:^#202^$074Z", "M:^#053^$178Z", "M:^$005Z", "M:^$255Z"};
        logic [1:0] u [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
        logic [6:0] cnt [4] = '{7'h0A, 7'h32, 7'h05, 7'h00};
        int i;
        for (i = 0; i < 4; i++) begin
            i_host.send_str(m[i], 1'b1);
            wait_show();
            chk(tmoUnit, u[i], "timeout unit");
            if (i == 1) begin
                chk(tmoMs, cnt[i], "timeout tens of ms");
            end else if (i != 3) begin
                chk(tmoValue, cnt[i], "timeout count");
            end
            if (i < 2) begin
                chk(pinAt >= 0 && pinAt < tmrAt && tmrAt < showAt, 1, "step order");
                chk(pinFlags, (i == 0) ? 8'hCA : 8'h35, "pin flags");
            end else begin
                chk(pinAt, -1, "pin strobe without request");
            end
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        dispAddr = '0;
        fails = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(busy, 0, "busy after reset");
        s_basic();
        s_ext();
        s_lines();
        s_blink();
        s_pin();
        summarize();
    end
endmodule
